/* File: src/psopd_defines.vh */
// constants for the pipelined sample output block with power-down
`ifndef PSOPD_DEFINES_VH
`define PSOPD_DEFINES_VH
`define PSOPD_DATA_W        8
`define PSOPD_LATENCY       5
`define PSOPD_CLK_MHZ       125
`define PSOPD_RECOVER_NS    1000
`define PSOPD_RECOVER_CYC   ((`PSOPD_RECOVER_NS * `PSOPD_CLK_MHZ) / 1000)
`define PSOPD_ZERO_CODE     8'h00
`endif

/* File: src/psopd_pipe.v */
// delay line of sample words with a hold enable
`timescale 1ns/10ps
module psopd_pipe
#(
    parameter WIDTH = 8,
    parameter DEPTH = 5
)
(
    input  wire             i_clk,
    input  wire             i_nrst,
    input  wire             i_hold,
    input  wire [WIDTH-1:0] i_data,
    output wire [WIDTH-1:0] o_data
);
    reg [WIDTH-1:0] stage_reg [0:DEPTH-1];
    genvar g;
    ////////////////////////////////////////////////////////////////////////////////
    // each stage advances one place per edge unless held
    generate
        for (g = 0; g < DEPTH; g = g + 1)
        begin : g_stage
            always @(posedge i_clk or negedge i_nrst)
            begin
                if (!i_nrst)
                    stage_reg[g] <= {WIDTH{1'b0}};
                else if (!i_hold)
                    stage_reg[g] <= (g == 0) ? i_data : stage_reg[(g == 0) ? 0 : g - 1];
            end
        end
    endgenerate
    assign o_data = stage_reg[DEPTH-1];
endmodule // psopd_pipe

/* File: src/psopd_top.v */
// sample pipeline with five-cycle latency, low-power hold and recovery flag
// Summary of operation
// - input sampled each rising edge; its word appears seven cycles later.
// - a new output word is produced every clock while clock runs, except in low-power mode.
// - output words are 8-bit straight unsigned binary.
// - input below bottom level gives an all-zero word.
// - normal while low_power_request low; low-power mode while it is high.
// - in low-power mode outputs hold the last result before entry.
// - with clock stopped, outputs keep the last code.
// - latency counted from conversion start to output driver stage.
`timescale 1ns/10ps
`include "psopd_defines.vh"
module psopd_top
#(
    parameter DATA_W      = `PSOPD_DATA_W,
    parameter LATENCY     = `PSOPD_LATENCY,
    parameter RECOVER_CYC = `PSOPD_RECOVER_CYC
)
(
    input  wire              I_CORE_CLK,
    input  wire              I_NRST,
    input  wire [DATA_W-1:0] I_SAMPLE,
    input  wire              I_BELOW_BOTTOM,
    input  wire              I_LOW_POWER_REQUEST,
    output reg  [DATA_W-1:0] O_SAMPLE_WORD,
    output reg               O_LOW_POWER_ACTIVE,
    output reg               O_WORD_SETTLED
);
    ////////////////////////////////////////////////////////////////////////////////
    // timing notes
    // a pin value takes two edges to reach the sync stage, then LATENCY edges to the output
    // the synchronisers are never frozen, so samples arriving in low power are dropped
    // on exit the frozen words drain first; the settled flag stays low until they are gone
    // a recovery count shorter than the pipeline is raised to the pipeline length
    // stopping the clock freezes every register, so the outputs simply keep their code
    // under-range is carried beside the word and forced to the zero code before the pipe
    ////////////////////////////////////////////////////////////////////////////////
    // counter width and control states
    localparam CNT_W      = 16;
    // recovery never shorter than the pipeline, so stale frozen words stay masked
    localparam RECOVER_LD = (RECOVER_CYC > LATENCY) ? RECOVER_CYC : LATENCY;
    localparam ST_RUN     = 3'h1;           // converting, words valid
    localparam ST_SLEEP   = 3'h2;           // low power, pipeline and output frozen
    localparam ST_WAKE    = 3'h4;           // released, recovery still running
    reg  [DATA_W-1:0] smp_meta_reg;
    reg  [DATA_W-1:0] smp_sync_reg;
    reg               below_meta_reg;
    reg               below_sync_reg;
    reg               lp_meta_reg;
    reg               lp_sync_reg;
    reg  [2:0]        state_reg;
    reg  [2:0]        state_next;
    reg  [CNT_W-1:0]  recover_reg;
    reg  [CNT_W-1:0]  recover_next;
    wire [CNT_W-1:0]  recover_load;
    wire [CNT_W-1:0]  recover_dec;
    wire [DATA_W-1:0] pipe_in;
    wire [DATA_W-1:0] pipe_out;
    wire              freeze;
    ////////////////////////////////////////////////////////////////////////////////
    // two-flop synchroniser for the sample pins
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            smp_meta_reg <= {DATA_W{1'b0}};
            smp_sync_reg <= {DATA_W{1'b0}};
        end
        else
        begin
            smp_meta_reg <= I_SAMPLE;
            smp_sync_reg <= smp_meta_reg;
        end
    end
    // two-flop synchroniser for the under-range flag
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            below_meta_reg <= 1'b0;
            below_sync_reg <= 1'b0;
        end
        else
        begin
            below_meta_reg <= I_BELOW_BOTTOM;
            below_sync_reg <= below_meta_reg;
        end
    end
    // two-flop synchroniser for the low-power request
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            lp_meta_reg <= 1'b0;
            lp_sync_reg <= 1'b0;
        end
        else
        begin
            lp_meta_reg <= I_LOW_POWER_REQUEST;
            lp_sync_reg <= lp_meta_reg;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // clamp under-range to zero code; word kept as unsigned binary
    assign pipe_in = below_sync_reg ? `PSOPD_ZERO_CODE : smp_sync_reg;
    // the whole pipeline stops while low power is synced in
    assign freeze = lp_sync_reg;
    // recovery load and decrement, cut to the counter width
    assign recover_load = RECOVER_LD[CNT_W-1:0];
    assign recover_dec  = recover_reg - {{(CNT_W-1){1'b0}}, 1'b1};
    // pipeline frozen in low power so the last word is retained
    psopd_pipe
    #(
        .WIDTH (DATA_W),
        .DEPTH (LATENCY - 1)
    )
    u_pipe
    (
        .i_clk  (I_CORE_CLK),
        .i_nrst (I_NRST),
        .i_hold (freeze),
        .i_data (pipe_in),
        .o_data (pipe_out)
    );
    ////////////////////////////////////////////////////////////////////////////////
    // control states: run, sleep while frozen, wake while recovery counts down
    always @*
    begin
        state_next   = state_reg;
        recover_next = recover_reg;
        case (state_reg)
            ST_RUN:
            begin
                if (lp_sync_reg)
                begin
                    state_next   = ST_SLEEP;
                    recover_next = recover_load;
                end
            end
            ST_SLEEP:
            begin
                recover_next = recover_load;
                if (!lp_sync_reg)
                begin
                    state_next = ST_WAKE;
                end
            end
            ST_WAKE:
            begin
                if (lp_sync_reg)
                begin
                    state_next   = ST_SLEEP;
                    recover_next = recover_load;
                end
                else
                begin
                    recover_next = recover_dec;
                    if (recover_dec == {CNT_W{1'b0}})
                        state_next = ST_RUN;
                end
            end
            default:
            begin
                state_next   = ST_RUN;
                recover_next = {CNT_W{1'b0}};
            end
        endcase
    end
    ////////////////////////////////////////////////////////////////////////////////
    // control state and recovery counter registers
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            state_reg   <= ST_RUN;
            recover_reg <= {CNT_W{1'b0}};
        end
        else
        begin
            state_reg   <= state_next;
            recover_reg <= recover_next;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // output word: final pipeline place, held while frozen
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_SAMPLE_WORD <= {DATA_W{1'b0}};
        end
        else if (!freeze)
        begin
            O_SAMPLE_WORD <= pipe_out;
        end
    end
    ////////////////////////////////////////////////////////////////////////////////
    // low-power indication follows the synced request
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_LOW_POWER_ACTIVE <= 1'b0;
        end
        else
        begin
            O_LOW_POWER_ACTIVE <= lp_sync_reg;
        end
    end
    // words flagged valid only once back in the run state
    always @(posedge I_CORE_CLK or negedge I_NRST)
    begin
        if (!I_NRST)
        begin
            O_WORD_SETTLED <= 1'b0;
        end
        else
        begin
            O_WORD_SETTLED <= (state_next == ST_RUN);
        end
    end
endmodule // psopd_top

/* File: tb/psopd_chk_sva.sv */
// checker for the sample pipeline
`timescale 1ns/10ps
module psopd_chk(
    input wire       I_CORE_CLK,
    input wire       I_NRST,
    input wire [7:0] I_SAMPLE,
    input wire       I_BELOW_BOTTOM,
    input wire       I_LOW_POWER_REQUEST,
    input wire [7:0] O_SAMPLE_WORD,
    input wire       O_LOW_POWER_ACTIVE,
    input wire       O_WORD_SETTLED);
    default clocking @(posedge I_CORE_CLK); endclocking
    default disable iff (!I_NRST);
    logic [3:0] q;
    // clean cycles since reset or low power
    always @(posedge I_CORE_CLK or negedge I_NRST)
        if (!I_NRST) q <= 4'h0;
        else if (I_LOW_POWER_REQUEST) q <= 4'h0;
        else if (q != 4'hF) q <= q + 4'h1;
    sequence s_held; O_LOW_POWER_ACTIVE [*2]; endsequence
    sequence s_recovering; !O_WORD_SETTLED [*3]; endsequence
    property p_rec; $fell(O_LOW_POWER_ACTIVE) |-> s_recovering; endproperty
    property p_lat; q > 4'h9 && !$past(I_BELOW_BOTTOM, 7) |-> O_SAMPLE_WORD == $past(I_SAMPLE, 7); endproperty
    property p_zero; q > 4'h9 && $past(I_BELOW_BOTTOM, 7) |-> O_SAMPLE_WORD == 8'h00; endproperty
    property p_lp; $past(I_NRST, 3) |-> O_LOW_POWER_ACTIVE == $past(I_LOW_POWER_REQUEST, 3); endproperty
    property p_hold; s_held |-> $stable(O_SAMPLE_WORD); endproperty
    property p_mask; O_LOW_POWER_ACTIVE |-> !O_WORD_SETTLED; endproperty
    a_lat: assert property (p_lat) else $error("late word");
    a_zero: assert property (p_zero) else $error("no zero");
    a_lp: assert property (p_lp) else $error("low power");
    a_hold: assert property (p_hold) else $error("no hold");
    a_mask: assert property (p_mask) else $error("settled");
    a_rec: assert property (p_rec) else $error("settled during recovery");
endmodule // psopd_chk
bind psopd_top psopd_chk i_psopd_chk(.*);

/* File: tb/psopd_sink.sv */
// downstream capture of sample words
`timescale 1ns/10ps
module psopd_sink(
    input  wire       i_clk,
    input  wire [7:0] i_word,
    input  wire       i_settled,
    output reg  [7:0] o_kept);
    // take words only once settled
    always @(posedge i_clk) if (i_settled) o_kept <= i_word;
endmodule // psopd_sink

/* File: tb/psopd_top_tb.sv */
// bench for the sample pipeline
`timescale 1ns/10ps
module psopd_top_tb;
    logic       I_CORE_CLK = 0, I_NRST = 0, I_BELOW_BOTTOM = 0, I_LOW_POWER_REQUEST = 0, run = 1;
    logic [7:0] I_SAMPLE = 8'h00, held;
    wire  [7:0] O_SAMPLE_WORD, kept;
    wire        O_LOW_POWER_ACTIVE, O_WORD_SETTLED;
    int         mismatches = 0, total_checks = 0, i;
    psopd_top #(.RECOVER_CYC(4)) i_psopd_top(.*);
    psopd_sink i_psopd_sink(.i_clk(I_CORE_CLK), .i_word(O_SAMPLE_WORD), .i_settled(O_WORD_SETTLED), .o_kept(kept));
    // clock runs while run is set, steady and glitch-free
    always #4 I_CORE_CLK = I_CORE_CLK ^ run;
    task chk(string n, logic [7:0] s, logic [7:0] e);
        total_checks++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task t_stream;
        for (i = 0; i < 24; i++)
        begin
            @(negedge I_CORE_CLK);
            if (i > 6) chk("word", O_SAMPLE_WORD, i == 17 ? 8'h00 : 8'((i - 7) * 37));
            I_SAMPLE = 8'(i * 37);
            I_BELOW_BOTTOM = (i == 10);
        end
    endtask
    task t_lowpow;
        I_LOW_POWER_REQUEST = 1;
        repeat (3) @(negedge I_CORE_CLK);
        held = O_SAMPLE_WORD;
        chk("active", {7'h00, O_LOW_POWER_ACTIVE}, 8'h01);
        repeat (9) @(negedge I_CORE_CLK) I_SAMPLE = I_SAMPLE + 8'h11;
        chk("hold", O_SAMPLE_WORD, held);
        I_LOW_POWER_REQUEST = 0;
        repeat (4) @(negedge I_CORE_CLK);
        chk("masked", {7'h00, O_WORD_SETTLED}, 8'h00);
        for (i = 0; i < 30 && O_WORD_SETTLED !== 1'b1; i++) @(negedge I_CORE_CLK);
        chk("ready", {7'h00, O_WORD_SETTLED}, 8'h01);
        chk("wake", 8'(i), 8'h04);
        chk("inactive", {7'h00, O_LOW_POWER_ACTIVE}, 8'h00);
        chk("fresh", O_SAMPLE_WORD, I_SAMPLE);
    endtask
    task t_reset;
        @(negedge I_CORE_CLK);
        I_NRST = 0;
        @(negedge I_CORE_CLK);
        chk("rst word", O_SAMPLE_WORD, 8'h00);
        chk("rst settled", {7'h00, O_WORD_SETTLED}, 8'h00);
        I_NRST = 1;
        @(negedge I_CORE_CLK);
        chk("rst wake", {7'h00, O_WORD_SETTLED}, 8'h01);
    endtask
    task t_clkstop;
        I_SAMPLE = 8'hA5;
        repeat (9) @(negedge I_CORE_CLK);
        run = 0;
        I_SAMPLE = 8'h5A;
        #100;
        chk("stop", O_SAMPLE_WORD, 8'hA5);
        chk("kept", kept, 8'hA5);
        run = 1;
    endtask
    task tally_and_finish;
        $display("checks %0d mismatches %0d", total_checks, mismatches);
        if (mismatches == 0 && total_checks > 0)
            $display("All checks passed");
        else
            $display("Checks failed");
        $finish;
    endtask
    // main sequence
    initial
    begin
        repeat (20) @(negedge I_CORE_CLK);
        chk("reset", O_SAMPLE_WORD, 8'h00);
        I_NRST = 1;
        t_stream;
        t_lowpow;
        t_stream;
        t_reset;
        t_clkstop;
        tally_and_finish;
    end
    // cut a hang short
    initial
    begin
        #100000;
        mismatches++;
        tally_and_finish;
    end
endmodule // psopd_top_tb
